// File: design/nor_seq_defines.svh
// constants of the serial nor erase and suspend sequencer
`ifndef NOR_SEQ_DEFINES_SVH
`define NOR_SEQ_DEFINES_SVH
`define CLK_MHZ       125
`define CYC_PER_MS    (`CLK_MHZ * 1000)
`define SSE_TIME_MS   50
`define SE_TIME_MS    150
`define BE_TIME_MS    1000
`define PP_TIME_US    500
`define SUSP_LAT_US   30
`define SUSP_LAT_CYC  (`SUSP_LAT_US * `CLK_MHZ)
`define CMD_WREN      8'h10
`define CMD_SSE       8'h11
`define CMD_SE        8'h12
`define CMD_BE        8'h13
`define CMD_PROG      8'h14
`define CMD_SUSP      8'h15
`define CMD_RES       8'h16
`define CMD_RDSR      8'h17
`define CMD_RDFS      8'h18
`define CMD_CLRFS     8'h19
`define CMD_READ      8'h1a
`define FS_ESUS       6
`define FS_EERR       5
`define FS_PERR       4
`define FS_PSUS       2
`define FS_PROT       1
`define REG_CTRL      8'h00
`define REG_PROT      8'h04
`define REG_LOCK      8'h08
`define REG_STAT      8'h0c
`define CTRL_A4       0
`define CTRL_FAIL     1
`define ADDR_BYTES3   4'd3
`define ADDR_BYTES4   4'd4
`define ERASED_BYTE   8'hff
`define UNDEF_BYTE    8'h00
`define LINK_IDLE     3'b100
`endif

// File: design/nor_seq_pkg.sv
// types shared by the nor sequencer
package nor_seq_pkg;
  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_RUN   = 2'b01,
    OP_SUSPW = 2'b10
  } op_state_t;
  typedef enum logic [1:0] {
    K_SSE  = 2'b00,
    K_SE   = 2'b01,
    K_BE   = 2'b10,
    K_PROG = 2'b11
  } op_kind_t;
endpackage

// File: design/nor_seq.sv
// serial nor command sequencer: erase, suspend, resume, flags
// Behaviour
// - erase sets chosen subsector, sector or whole array to all ones
// - erase with write enable latch clear is ignored, no flag set
// - without select rising the command does nothing, latch stays set
// - erase of protected region refused, latch kept, flags 1 and 5 set
// - whole-array erase refused if any sector locked, flags 1 and 5
// - during erase controller-ready reads zero, write-in-progress one
// - at completion busy clears, ready returns; both pollable throughout
// - write enable latch clears at end of every erase
// - erase over its time limit clears latch and sets erase error
// - each erase kind runs self-timed for its own duration
// - any address within region accepted, bits taken on clock rise
// - suspend sets flag 2 for program, flag 6 for erase
// - ready flag returns after suspend latency, marking suspended state
// - if less than latency remains, finish and clear flag 2 or 6
// - suspend state volatile; flag register reads 80h after reset
// - one nesting: program inside erase; resumes pop newest first
// - reads of suspended page return undefined data
// - program to erase-suspended sector ignored, flag 4, latch kept
// - resumed erase does not recheck changed lock bits
// - resume ignored unless suspended; else busy until completion
// - address takes three or four bytes per configured mode
`timescale 1ns/1ps
`include "nor_seq_defines.svh"
module nor_seq #(
  parameter int unsigned SSE_CYC = `SSE_TIME_MS * `CYC_PER_MS,
  parameter int unsigned SE_CYC  = `SE_TIME_MS * `CYC_PER_MS,
  parameter int unsigned BE_CYC  = `BE_TIME_MS * `CYC_PER_MS,
  parameter int unsigned PP_CYC  = `PP_TIME_US * `CLK_MHZ
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // ahb-lite register slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // serial link from the host controller
  input  wire logic        sel_n,
  input  wire logic        sclk,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_oe_n
);
  import nor_seq_pkg::*;

  // ****************
  // helpers
  // ****************
  function automatic logic [3:0] need_bytes(input logic [7:0] c,
                                            input logic [3:0] n);
    logic [3:0] r;
    r = 4'd1;
    if (c == `CMD_SSE || c == `CMD_SE)
      r = 4'd1 + n;
    else if (c == `CMD_PROG)
      r = 4'd2 + n;
    return r;
  endfunction

  // one byte per subsector models the array contents
  function automatic logic [7:0] mem_idx(input logic [31:0] a);
    return a[19:12];
  endfunction

  function automatic logic [3:0] sec_of(input logic [31:0] a);
    return a[19:16];
  endfunction

  function automatic logic is_erase(input logic [7:0] c);
    return c == `CMD_SSE || c == `CMD_SE || c == `CMD_BE;
  endfunction

  // ****************
  // state
  // ****************
  logic [2:0]  s1_q, s2_q, s3_q;
  logic [2:0]  bit_q;
  logic [7:0]  sh_q, cmd_q, data_q, tx_q;
  logic [3:0]  nbyte_q;
  logic [31:0] addr_q;
  logic        sdo_q, oe_n_q, exec_q;
  logic        addr4_q, fail_q;
  logic [15:0] prot_q, lock_q;
  op_state_t   op_q;
  op_kind_t    kind_q, es_kind_q;
  logic [31:0] act_addr_q, es_addr_q, ps_addr_q;
  logic [7:0]  act_data_q, ps_data_q;
  logic [31:0] rem_q, es_rem_q, ps_rem_q;
  logic [11:0] lat_q;
  logic        wel_q, spend_q, es_v_q, ps_v_q;
  logic [6:0]  flags_q;
  logic [7:0]  mem_q [0:255];
  logic        rd_pend_q;
  logic [7:0]  ah_a_q;
  logic        ah_wr_q;
  logic [31:0] hrdata_q;

  // ****************
  // link sampling
  // ****************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_q <= `LINK_IDLE;
      s2_q <= `LINK_IDLE;
      s3_q <= `LINK_IDLE;
    end
    else
    begin
      s1_q <= {sel_n, sclk, serial_data_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  wire sel_lo   = ~s2_q[2];
  wire sel_rise = s2_q[2] & ~s3_q[2];
  wire clk_rise = s2_q[1] & ~s3_q[1];
  wire clk_fall = ~s2_q[1] & s3_q[1];
  wire [7:0] nb = {sh_q[6:0], s2_q[0]};
  wire [3:0] na = addr4_q ? `ADDR_BYTES4 : `ADDR_BYTES3;
  wire [31:0] addr_nx = addr4_q ? {addr_q[23:0], nb}
                                : {8'h00, addr_q[15:0], nb};
  wire idle = op_q == OP_IDLE;
  wire [7:0] stat_b = {6'h00, wel_q, ~idle};
  wire [7:0] flag_b = {idle, flags_q};
  wire [31:0] rd_a = (nbyte_q == na) ? addr_nx : addr_q;
  wire rd_hide = ps_v_q && rd_a[19:8] == ps_addr_q[19:8];
  wire [7:0] rd_b = rd_hide ? `UNDEF_BYTE : mem_q[mem_idx(rd_a)];
  wire rd_on = nbyte_q != 4'd0 &&
               (cmd_q == `CMD_RDSR || cmd_q == `CMD_RDFS ||
                (cmd_q == `CMD_READ && nbyte_q > na));

  // ****************
  // frame shifter
  // ****************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bit_q   <= 3'd0;
      sh_q    <= 8'h00;
      nbyte_q <= 4'd0;
      cmd_q   <= 8'h00;
      addr_q  <= 32'h0;
      data_q  <= 8'h00;
      tx_q    <= 8'h00;
      sdo_q   <= 1'b0;
    end
    else if (!sel_lo)
    begin
      bit_q   <= 3'd0;
      nbyte_q <= 4'd0;
    end
    else if (clk_rise)
    begin
      sh_q  <= nb;
      bit_q <= bit_q + 3'd1;
      if (bit_q == 3'd7)
      begin
        if (nbyte_q != 4'hf)
          nbyte_q <= nbyte_q + 4'd1;
        if (nbyte_q == 4'd0)
        begin
          cmd_q  <= nb;
          addr_q <= 32'h0;
          tx_q   <= (nb == `CMD_RDFS) ? flag_b : stat_b;
        end
        else
        begin
          if (nbyte_q <= na)
            addr_q <= addr_nx;
          if (nbyte_q == na + 4'd1)
            data_q <= nb;
          if (cmd_q == `CMD_READ)
            tx_q <= rd_b;
          else if (cmd_q == `CMD_RDFS)
            tx_q <= flag_b;
          else
            tx_q <= stat_b;
        end
      end
    end
    else if (clk_fall)
    begin
      sdo_q <= tx_q[7];
      tx_q  <= {tx_q[6:0], 1'b0};
    end
  end

  // act only when select rises on a byte boundary
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      exec_q <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else
    begin
      exec_q <= sel_rise && bit_q == 3'd0 && nbyte_q != 4'd0 &&
                nbyte_q >= need_bytes(cmd_q, na);
      oe_n_q <= !(sel_lo && rd_on);
    end
  end

  assign serial_data_out  = sdo_q;
  assign serial_data_oe_n = oe_n_q;

  // ****************
  // command decode
  // ****************
  wire x_erase = exec_q && is_erase(cmd_q);
  wire x_prog  = exec_q && cmd_q == `CMD_PROG;
  wire x_res   = exec_q && cmd_q == `CMD_RES;
  wire prot_hit = (cmd_q == `CMD_BE) ? |lock_q
                                     : prot_q[sec_of(addr_q)];
  // new erase only when idle and nothing suspended
  wire erase_ok = x_erase && idle && !es_v_q && !ps_v_q && wel_q;
  wire erase_go = erase_ok && !prot_hit;
  wire erase_bad = erase_ok && prot_hit;
  wire prog_blk = x_prog && idle && es_v_q && !ps_v_q &&
                  sec_of(addr_q) == sec_of(es_addr_q);
  wire prog_ok = x_prog && idle && !ps_v_q && wel_q && !prog_blk;
  wire prog_go = prog_ok && !prot_q[sec_of(addr_q)];
  wire prog_bad = prog_ok && prot_q[sec_of(addr_q)];
  wire susp_go = exec_q && cmd_q == `CMD_SUSP && op_q == OP_RUN &&
                 !spend_q;
  wire res_go = x_res && idle && (es_v_q || ps_v_q);
  wire done = op_q == OP_RUN && rem_q == 32'd1;

  // ****************
  // operation sequencer
  // ****************
  // all suspend context is reset state, flags read 80h
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      op_q       <= OP_IDLE;
      kind_q     <= K_SSE;
      act_addr_q <= 32'h0;
      act_data_q <= 8'h00;
      rem_q      <= 32'h0;
      lat_q      <= 12'h000;
      wel_q      <= 1'b0;
      spend_q    <= 1'b0;
      flags_q    <= 7'h00;
      es_v_q     <= 1'b0;
      es_kind_q  <= K_SSE;
      es_addr_q  <= 32'h0;
      es_rem_q   <= 32'h0;
      ps_v_q     <= 1'b0;
      ps_addr_q  <= 32'h0;
      ps_data_q  <= 8'h00;
      ps_rem_q   <= 32'h0;
    end
    else
    begin
      // clear first so a same-cycle set wins
      if (exec_q && cmd_q == `CMD_CLRFS)
      begin
        flags_q[`FS_EERR] <= 1'b0;
        flags_q[`FS_PERR] <= 1'b0;
        flags_q[`FS_PROT] <= 1'b0;
      end
      if (!idle)
        rem_q <= rem_q - 32'd1;
      unique case (op_q)
        OP_IDLE:
        begin
          if (erase_go)
          begin
            op_q       <= OP_RUN;
            act_addr_q <= addr_q;
            if (cmd_q == `CMD_SSE)
            begin
              kind_q <= K_SSE;
              rem_q  <= SSE_CYC;
            end
            else if (cmd_q == `CMD_SE)
            begin
              kind_q <= K_SE;
              rem_q  <= SE_CYC;
            end
            else
            begin
              kind_q <= K_BE;
              rem_q  <= BE_CYC;
            end
          end
          else if (prog_go)
          begin
            op_q       <= OP_RUN;
            kind_q     <= K_PROG;
            act_addr_q <= addr_q;
            act_data_q <= data_q;
            rem_q      <= PP_CYC;
          end
          // resumed erase skips the lock check
          else if (res_go)
          begin
            op_q <= OP_RUN;
            if (ps_v_q)
            begin
              ps_v_q            <= 1'b0;
              kind_q            <= K_PROG;
              act_addr_q        <= ps_addr_q;
              act_data_q        <= ps_data_q;
              rem_q             <= ps_rem_q;
              flags_q[`FS_PSUS] <= 1'b0;
            end
            else
            begin
              es_v_q            <= 1'b0;
              kind_q            <= es_kind_q;
              act_addr_q        <= es_addr_q;
              rem_q             <= es_rem_q;
              flags_q[`FS_ESUS] <= 1'b0;
            end
          end
        end
        OP_RUN:
        begin
          if (done)
          begin
            op_q    <= OP_IDLE;
            wel_q   <= 1'b0;
            spend_q <= 1'b0;
            if (kind_q == K_PROG)
              flags_q[`FS_PSUS] <= 1'b0;
            else
            begin
              flags_q[`FS_ESUS] <= 1'b0;
              if (fail_q)
                flags_q[`FS_EERR] <= 1'b1;
            end
          end
          else if (susp_go)
          begin
            spend_q <= 1'b1;
            if (kind_q == K_PROG)
              flags_q[`FS_PSUS] <= 1'b1;
            else
              flags_q[`FS_ESUS] <= 1'b1;
            if (rem_q > 32'(`SUSP_LAT_CYC) + 32'd1)
            begin
              op_q  <= OP_SUSPW;
              lat_q <= 12'(`SUSP_LAT_CYC);
            end
          end
        end
        OP_SUSPW:
        begin
          if (lat_q == 12'd1)
          begin
            op_q    <= OP_IDLE;
            spend_q <= 1'b0;
            if (kind_q == K_PROG)
            begin
              ps_v_q    <= 1'b1;
              ps_addr_q <= act_addr_q;
              ps_data_q <= act_data_q;
              ps_rem_q  <= rem_q - 32'd1;
            end
            else
            begin
              es_v_q    <= 1'b1;
              es_kind_q <= kind_q;
              es_addr_q <= act_addr_q;
              es_rem_q  <= rem_q - 32'd1;
            end
          end
          else
            lat_q <= lat_q - 12'd1;
        end
        default:
          op_q <= OP_IDLE;
      endcase
      if (erase_bad)
      begin
        flags_q[`FS_PROT] <= 1'b1;
        flags_q[`FS_EERR] <= 1'b1;
      end
      if (prog_bad)
      begin
        flags_q[`FS_PROT] <= 1'b1;
        flags_q[`FS_PERR] <= 1'b1;
      end
      if (prog_blk)
        flags_q[`FS_PERR] <= 1'b1;
      if (exec_q && cmd_q == `CMD_WREN)
        wel_q <= 1'b1;
    end
  end

  // ****************
  // array model
  // ****************
  // contents are not reset: flash keeps data over reset
  always_ff @(posedge clk)
  begin
    if (done)
    begin
      unique case (kind_q)
        K_PROG:
          mem_q[mem_idx(act_addr_q)] <=
            mem_q[mem_idx(act_addr_q)] & act_data_q;
        K_SSE:
          if (!fail_q)
            mem_q[mem_idx(act_addr_q)] <= `ERASED_BYTE;
        K_SE:
          if (!fail_q)
            for (int i = 0; i < 16; i++)
              mem_q[{sec_of(act_addr_q), 4'(i)}] <= `ERASED_BYTE;
        K_BE:
          if (!fail_q)
            for (int i = 0; i < 256; i++)
              mem_q[8'(i)] <= `ERASED_BYTE;
      endcase
    end
  end

  // ****************
  // register slave
  // ****************
  // reads take one wait state so a preceding write is seen
  wire ah_go = hsel && htrans[1] && hready;
  logic [31:0] rd_w;
  always_comb
  begin
    rd_w = 32'h0;
    unique case (ah_a_q)
      `REG_CTRL: rd_w = {30'h0, fail_q, addr4_q};
      `REG_PROT: rd_w = {16'h0, prot_q};
      `REG_LOCK: rd_w = {16'h0, lock_q};
      `REG_STAT: rd_w = {16'h0, flag_b, stat_b};
      default:   rd_w = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ah_a_q    <= 8'h00;
      ah_wr_q   <= 1'b0;
      rd_pend_q <= 1'b0;
      hrdata_q  <= 32'h0;
    end
    else
    begin
      ah_wr_q   <= ah_go && hwrite;
      rd_pend_q <= ah_go && !hwrite;
      if (ah_go)
        ah_a_q <= haddr[7:0];
      if (rd_pend_q)
        hrdata_q <= rd_w;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      addr4_q <= 1'b0;
      fail_q  <= 1'b0;
      prot_q  <= 16'h0000;
      lock_q  <= 16'h0000;
    end
    else if (ah_wr_q)
    begin
      unique case (ah_a_q)
        `REG_CTRL:
        begin
          addr4_q <= hwdata[`CTRL_A4];
          fail_q  <= hwdata[`CTRL_FAIL];
        end
        `REG_PROT: prot_q <= hwdata[15:0];
        `REG_LOCK: lock_q <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  assign hreadyout = ~rd_pend_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // ****************
  // checks
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_no_wel;
    x_erase && idle && !wel_q && !es_v_q && !ps_v_q
      |=> idle && $stable(flags_q);
  endproperty
  a_no_wel: assert property (p_no_wel)
    else $error("erase ran without write enable");

  property p_prot_sub;
    erase_bad && cmd_q != `CMD_BE
      |=> flags_q[`FS_PROT] && flags_q[`FS_EERR] && wel_q && idle;
  endproperty
  a_prot_sub: assert property (p_prot_sub)
    else $error("protected erase not refused");

  property p_lock_all;
    erase_bad && cmd_q == `CMD_BE |=> idle && wel_q && flags_q[`FS_PROT];
  endproperty
  a_lock_all: assert property (p_lock_all)
    else $error("locked array erase not refused");

  property p_run;
    erase_go |=> op_q == OP_RUN && stat_b[0] && !flag_b[7];
  endproperty
  a_run: assert property (p_run)
    else $error("erase start flags wrong");

  property p_done;
    done && !exec_q |=> !wel_q && flag_b[7] && !stat_b[0];
  endproperty
  a_done: assert property (p_done)
    else $error("completion left latch or busy set");

  property p_tmo;
    done && fail_q && kind_q != K_PROG |=> flags_q[`FS_EERR];
  endproperty
  a_tmo: assert property (p_tmo)
    else $error("timeout without erase error");

  property p_susp;
    susp_go && kind_q != K_PROG |=> flags_q[`FS_ESUS];
  endproperty
  a_susp: assert property (p_susp)
    else $error("erase suspend flag missing");

  property p_lat;
    op_q == OP_SUSPW && lat_q == 12'd1
      |=> idle && flag_b[7] && (es_v_q || ps_v_q);
  endproperty
  a_lat: assert property (p_lat)
    else $error("suspend latency end wrong");

  property p_res;
    x_res && idle && !es_v_q && !ps_v_q |=> idle [*2];
  endproperty
  a_res: assert property (p_res)
    else $error("resume acted while not suspended");

  property p_blk;
    prog_blk |=> flags_q[`FS_PERR] && wel_q == $past(wel_q) && idle;
  endproperty
  a_blk: assert property (p_blk)
    else $error("program to suspended sector not refused");

  property p_busy;
    x_erase && op_q == OP_RUN && !done
      |=> $stable(kind_q) && $stable(act_addr_q);
  endproperty
  a_busy: assert property (p_busy)
    else $error("erase accepted while busy");

  c_done: cover property (done && kind_q != K_PROG);
  c_susp: cover property (op_q == OP_SUSPW ##1 idle);
  c_nest: cover property (es_v_q && ps_v_q);
  c_res:  cover property (res_go);

endmodule // nor_seq

// File: test/host_link.sv
// host-side serial link model: select, serial clock, data
`timescale 1ns/1ps
module host_link (
  // pacing clock
  input  wire logic clk,
  // link pins
  output logic      sel_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe_n
);
  initial
  begin
    sel_n = 1'b1;
    sclk  = 1'b0;
    sdi   = 1'b0;
  end

  // half of the 80 ns link period
  task automatic half();
    repeat (5) @(posedge clk);
  endtask

  // bits go out msb first from bit 47; sclk stands low between frames
  // select held low past the last latched bit, then raised
  task automatic frame(input logic [47:0] b, input int n,
                       output logic [7:0] r);
    r = 8'h00;
    @(posedge clk);
    sel_n <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      sdi <= b[47-i];
      half();
      // an undriven line must not pass for data
      r = {r[6:0], (sdo_oe_n === 1'b0) ? sdo : 1'bx};
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
    end
    half();
    sel_n <= 1'b1;
    sdi   <= ~sdi;
    half();
  endtask
endmodule // host_link

// File: test/testbench.sv
// self-checking bench for the nor erase and suspend sequencer
`timescale 1ns/1ps
`include "nor_seq_defines.svh"
module testbench;
  localparam int unsigned P_SSE = 8000;
  localparam int unsigned P_SE  = 9000;
  localparam int unsigned P_BE  = 10000;
  logic        clk, arst_n, hwrite, hrdy, sel_n, sclk, sdi, sdo, oe_n, hresp;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0]  rd;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  nor_seq #(.SSE_CYC(P_SSE), .SE_CYC(P_SE), .BE_CYC(P_BE),
    .PP_CYC(6000)) uut (.clk(clk), .arst_n(arst_n), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp),
    .hrdata(hrdata), .sel_n(sel_n), .sclk(sclk), .serial_data_in(sdi),
    .serial_data_out(sdo), .serial_data_oe_n(oe_n));
  host_link host (.clk(clk), .sel_n(sel_n), .sclk(sclk), .sdi(sdi),
    .sdo(sdo), .sdo_oe_n(oe_n));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // a hung handshake ends the run here
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 70000)
    begin
      num_errors++;
      finish_test();
    end
  end

  // ****************
  // bus and link helpers
  // ****************
  task automatic finish_test();
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic stat(input logic [31:0] m, input logic [31:0] e);
    logic [31:0] s;
    ahb(1'b0, `REG_STAT, 32'h0, s);
    chk("status", e, s & m);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic op(input logic [7:0] c, input logic [23:0] a, input int n);
    host.frame({c, a, 16'h0}, n, rd);
  endtask

  task automatic wait_idle(output int n);
    logic [31:0] s;
    int          t0;
    t0 = cyc;
    do ahb(1'b0, `REG_STAT, 32'h0, s); while (s[0] !== 1'b0);
    n = cyc - t0;
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_frames();
    stat(32'hffff, 32'h8000);
    op(`CMD_SSE, 24'h012345, 32);
    stat(32'hffff, 32'h8000);
    op(`CMD_WREN, 24'h0, 8);
    // trailing partial byte stands for a frame never closed properly
    op(`CMD_SSE, 24'h012345, 35);
    stat(32'hffff, 32'h8002);
  endtask

  task automatic t_refuse();
    wr(`REG_PROT, 32'h0002);
    op(`CMD_SE, 24'h018000, 32);
    stat(32'hffff, 32'ha202);
    op(`CMD_CLRFS, 24'h0, 8);
    wr(`REG_PROT, 32'h0);
    wr(`REG_LOCK, 32'h0008);
    op(`CMD_BE, 24'h0, 8);
    stat(32'hffff, 32'ha202);
    op(`CMD_CLRFS, 24'h0, 8);
    wr(`REG_LOCK, 32'h0);
  endtask

  task automatic t_erase();
    int t0;
    int n;
    op(`CMD_WREN, 24'h0, 8);
    op(`CMD_SSE, 24'h012345, 32);
    t0 = cyc;
    stat(32'h8001, 32'h0001);
    op(`CMD_WREN, 24'h0, 8);
    op(`CMD_SE, 24'h050000, 32);
    stat(32'hffff, 32'h0003);
    while (cyc - t0 < P_SSE - 2000) @(posedge clk);
    // suspend too late to take effect
    op(`CMD_SUSP, 24'h0, 8);
    wait_idle(n);
    n = cyc - t0;
    chk("erase time", 1, 32'(n >= P_SSE - 20 && n <= P_SSE + 40));
    stat(32'hffff, 32'h8000);
    op(`CMD_READ, 24'h012fff, 40);
    chk("read byte", 32'hff, rd);
    wr(`REG_CTRL, 32'h1);
    host.frame({`CMD_READ, 32'h00012000, 8'h0}, 48, rd);
    chk("read byte 4b", 32'hff, rd);
    wr(`REG_CTRL, 32'h0);
  endtask

  task automatic t_timeout();
    int n;
    wr(`REG_CTRL, 32'h2);
    op(`CMD_WREN, 24'h0, 8);
    op(`CMD_SSE, 24'h040000, 32);
    wait_idle(n);
    stat(32'hffff, 32'ha000);
    op(`CMD_CLRFS, 24'h0, 8);
    wr(`REG_CTRL, 32'h0);
  endtask

  task automatic t_suspend();
    int n;
    op(`CMD_WREN, 24'h0, 8);
    op(`CMD_SE, 24'h020000, 32);
    repeat (100) @(posedge clk);
    op(`CMD_SUSP, 24'h0, 8);
    stat(32'h4000, 32'h4000);
    repeat (3800) @(posedge clk);
    op(`CMD_RDFS, 24'h0, 16);
    chk("flag byte", 32'hc0, rd);
    stat(32'hff01, 32'hc000);
    op(`CMD_WREN, 24'h0, 8);
    host.frame({`CMD_PROG, 24'h020100, 8'h00, 8'h0}, 40, rd);
    stat(32'hffff, 32'hd002);
    op(`CMD_CLRFS, 24'h0, 8);
    host.frame({`CMD_PROG, 24'h030000, 8'ha5, 8'h0}, 40, rd);
    op(`CMD_SUSP, 24'h0, 8);
    repeat (3800) @(posedge clk);
    stat(32'hff01, 32'hc400);
    op(`CMD_READ, 24'h030000, 40);
    chk("suspended read", {24'h0, `UNDEF_BYTE}, rd);
    op(`CMD_RES, 24'h0, 8);
    stat(32'hc401, 32'h4001);
    wait_idle(n);
    stat(32'hff01, 32'hc000);
    op(`CMD_RES, 24'h0, 8);
    stat(32'hc001, 32'h0001);
    wait_idle(n);
    stat(32'hffff, 32'h8000);
    op(`CMD_READ, 24'h02f000, 40);
    chk("sector byte", 32'hff, rd);
    op(`CMD_RES, 24'h0, 8);
    stat(32'hffff, 32'h8000);
  endtask

  task automatic t_bulk();
    int n;
    op(`CMD_WREN, 24'h0, 8);
    op(`CMD_BE, 24'h0, 8);
    op(`CMD_RDSR, 24'h0, 16);
    chk("status byte", 32'h03, rd);
    wait_idle(n);
    chk("bulk time", 1, 32'(n >= P_BE - 300 && n <= P_BE + 40));
    stat(32'hffff, 32'h8000);
    op(`CMD_READ, 24'h030000, 40);
    chk("array byte", 32'hff, rd);
  endtask

  // suspend context must not survive a reset
  task automatic t_reset();
    op(`CMD_WREN, 24'h0, 8);
    op(`CMD_SSE, 24'h060000, 32);
    op(`CMD_SUSP, 24'h0, 8);
    repeat (3800) @(posedge clk);
    stat(32'hff01, 32'hc000);
    arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    stat(32'hffff, 32'h8000);
    op(`CMD_RES, 24'h0, 8);
    stat(32'hffff, 32'h8000);
  endtask

  initial
  begin
    arst_n = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr  = 32'h0;
    hwdata = 32'h0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_frames();
    t_refuse();
    t_erase();
    t_timeout();
    t_suspend();
    t_bulk();
    t_reset();
    finish_test();
  end
endmodule // testbench
